// File: logic/lsio_cfg.svh
`ifndef LSIO_CFG_SVH
`define LSIO_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define LSIO_CLK_HZ       125000000
`define LSIO_PULSE_MS     5
`define LSIO_PULSE_CYC    (`LSIO_PULSE_MS * (`LSIO_CLK_HZ / 1000))
`define LSIO_PULSE_CNT_W  20

// ----------------------------------------
// Sizes
// ----------------------------------------
`define LSIO_N_OUT        64
`define LSIO_N_IN         32
`define LSIO_N_SIG        96
`define LSIO_LBL_WORDS    768
`define LSIO_LBL_AW       10

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LSIO_OFS_OUT_LO   8'h00
`define LSIO_OFS_OUT_HI   8'h04
`define LSIO_OFS_IN_STAT  8'h08
`define LSIO_OFS_IN_MODE  8'h0C
`define LSIO_OFS_IN_SET   8'h10
`define LSIO_OFS_IN_CLR   8'h14
`define LSIO_OFS_ON_EN0   8'h18
`define LSIO_OFS_OFF_EN0  8'h24
`define LSIO_OFS_IRQ_STAT 8'h30
`define LSIO_OFS_IRQ_MASK 8'h34
`define LSIO_OFS_LBL_ADDR 8'h38
`define LSIO_OFS_LBL_DATA 8'h3C
`define LSIO_OFS_HMI_RST  8'h40
`define LSIO_OFS_ROUTE0   8'h44

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define LSIO_IRQ_EVT      0
`define LSIO_IRQ_OVR      1
`define LSIO_IRQ_CPY      2
`define LSIO_IRQ_W        3
`define LSIO_EVT_EN_RST   32'hFFFF_FFFF
`define LSIO_ROUTE_RST    32'h0000_0000
`define LSIO_LAST_BYTE    32'h00FF_FFFF

`endif

// File: logic/lsio_pkg.sv
package lsio_pkg;

  // Event block of a signal
  typedef enum logic [1:0] {
    grp_none                 = 2'b00,
    event_group_outputs_low  = 2'b01,
    event_group_inputs       = 2'b10,
    event_group_outputs_high = 2'b11
  } lsio_grp_type;

  // Commanded input behaviour
  typedef enum logic {
    mode_hold  = 1'b0,
    mode_pulse = 1'b1
  } lsio_mode_type;

  // Label copy engine
  typedef enum logic {
    cpy_idle = 1'b0,
    cpy_run  = 1'b1
  } lsio_cpy_type;

endpackage : lsio_pkg

// File: logic/lsio_label_ram.sv
`timescale 1ns/1ns

module lsio_label_ram #(
  parameter int DW    = 32,
  parameter int AW    = 10,
  parameter int DEPTH = 768
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  if (DEPTH < 1 || DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("lsio_label_ram: depth does not fit the address width");
  end

  logic [DW-1:0] mem [0:DEPTH-1];

  // Write, out-of-range addresses dropped
  always_ff @(posedge clk)
  begin
    if (we && (int'(waddr) < DEPTH))
      mem[waddr] <= wdata;
  end

  // Registered read data
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata <= '0;
    else if (int'(raddr) < DEPTH)
      rdata <= mem[raddr];
    else
      rdata <= '0;
  end

endmodule : lsio_label_ram

// File: logic/lsio_cmd_cell.sv
`timescale 1ns/1ns

module lsio_cmd_cell #(
  parameter int CNT_W        = 20,
  parameter int PULSE_CYCLES = 625000
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Commands
  input  wire logic                  set_cmd,
  input  wire logic                  clr_cmd,
  input  wire lsio_pkg::lsio_mode_type mode,
  // Status
  output logic                       status
);

  // ----------------------------------------
  // Pulse timer and status
  // ----------------------------------------
  if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << CNT_W))
  begin : g_bad_pulse
    $error("lsio_cmd_cell: pulse length does not fit the counter");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             status_nxt;

  // Set beats clear; a new set restarts the pulse
  always_comb
  begin
    status_nxt = status;
    cnt_nxt    = cnt_r;
    if (set_cmd)
    begin
      status_nxt = 1'b1;
      cnt_nxt    = CNT_W'(PULSE_CYCLES - 1);
    end
    else if (clr_cmd)
    begin
      status_nxt = 1'b0;
      cnt_nxt    = '0;
    end
    else if (mode == lsio_pkg::mode_pulse && status)
    begin
      if (cnt_r == '0)
        status_nxt = 1'b0;
      else
        cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Restart always leaves the signal at zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      status <= 1'b0;
      cnt_r  <= '0;
    end
    else
    begin
      status <= status_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

endmodule : lsio_cmd_cell

// File: logic/lsio_logic_signals.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "lsio_cfg.svh"

module lsio_logic_signals #(
  parameter int PULSE_CYCLES = `LSIO_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Avalon-MM slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // User logic results and time base
  input  wire logic [63:0]          user_logic_result_signal,
  input  wire logic [31:0]          time_stamp,
  // Mimic switch commands
  input  wire logic                 mimic_set,
  input  wire logic                 mimic_clr,
  input  wire logic [4:0]           mimic_index,
  // Signal matrix
  output logic      [31:0]          commanded_binary_signal,
  output logic      [63:0]          func_block,
  output logic      [63:0]          group_change,
  output logic      [63:0]          relay_drive,
  output logic      [63:0]          lamp_drive,
  // Event stream to main buffer
  output logic                      evt_valid,
  output lsio_pkg::lsio_grp_type    evt_group,
  output logic      [4:0]           evt_index,
  output logic                      evt_on,
  output logic      [31:0]          evt_stamp,
  // Label lookup for event history
  input  wire logic [9:0]           hist_label_addr,
  output logic      [31:0]          hist_label_data,
  // Interrupt
  output logic                      irq
);

  localparam int NS = `LSIO_N_SIG;
  localparam int LW = `LSIO_LBL_WORDS;

  if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << `LSIO_PULSE_CNT_W))
  begin : g_bad_pulse
    $error("lsio_logic_signals: pulse length out of range");
  end

  // ----------------------------------------
  // Default label text
  // ----------------------------------------
  function automatic logic [31:0] lsio_default_word(input logic [6:0] sig,
                                                    input logic [2:0] word);
    logic [255:0] txt;
    logic [119:0] pfx_out;
    logic [111:0] pfx_in;
    logic [6:0]   num;
    int           plen;
    txt     = '0;
    pfx_out = "Logical output ";
    pfx_in  = "Logical input ";
    num     = (sig < 7'h20) ? sig + 7'h01 : sig - 7'h1F;
    plen    = (sig >= 7'h20 && sig < 7'h40) ? 14 : 15;
    for (int k = 0; k < 15; k++)
    begin
      if (plen == 14 && k < 14)
        txt[8*k +: 8] = pfx_in[8*(13-k) +: 8];
      else if (plen == 15)
        txt[8*k +: 8] = pfx_out[8*(14-k) +: 8];
    end
    if (num >= 7'h0A)
    begin
      txt[8*plen +: 8]     = 8'h30 + 8'(num / 7'h0A);
      txt[8*plen + 8 +: 8] = 8'h30 + 8'(num % 7'h0A);
    end
    else
      txt[8*plen +: 8] = 8'h30 + 8'(num);
    return txt[32*word +: 32];
  endfunction : lsio_default_word

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle per access keeps label reads and plain reads alike
  logic        wait_r;
  wire         bus_req = avs_read | avs_write;
  wire         bus_acc = bus_req & ~wait_r;
  wire         wr_en   = avs_write & ~wait_r;
  wire  [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire  [31:0] wr_bits = avs_writedata & be_mask;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      wait_r <= 1'b1;
    else
      wait_r <= ~(bus_req & wait_r);
  end

  // Byte-lane merge for read-write registers
  function automatic logic [31:0] lsio_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [31:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction : lsio_merge

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire [5:0] widx     = avs_address[7:2];
  wire       w_mode   = wr_en && avs_address == `LSIO_OFS_IN_MODE;
  wire       w_set    = wr_en && avs_address == `LSIO_OFS_IN_SET;
  wire       w_clr    = wr_en && avs_address == `LSIO_OFS_IN_CLR;
  wire       w_istat  = wr_en && avs_address == `LSIO_OFS_IRQ_STAT;
  wire       w_imask  = wr_en && avs_address == `LSIO_OFS_IRQ_MASK;
  wire       w_laddr  = wr_en && avs_address == `LSIO_OFS_LBL_ADDR;
  wire       w_ldata  = wr_en && avs_address == `LSIO_OFS_LBL_DATA;
  wire       w_hmi    = wr_en && avs_address == `LSIO_OFS_HMI_RST;
  wire       w_on     = wr_en && widx >= 6'h06 && widx <= 6'h08;
  wire       w_off    = wr_en && widx >= 6'h09 && widx <= 6'h0B;
  wire       w_route  = wr_en && widx >= 6'h11 && widx <= 6'h18;
  wire [1:0] on_sel   = 2'(widx - 6'h06);
  wire [1:0] off_sel  = 2'(widx - 6'h09);
  wire [2:0] rt_sel   = 3'(widx - 6'h11);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [31:0] in_mode_r;
  logic [31:0] on_en_r  [0:2];
  logic [31:0] off_en_r [0:2];
  logic [31:0] route_r  [0:7];
  logic [`LSIO_IRQ_W-1:0] irq_mask_r;
  logic [9:0]  lbl_addr_r;
  // Merged as a full word first; a function result cannot be sliced
  wire  [31:0] laddr_m = lsio_merge(32'(lbl_addr_r), avs_writedata, be_mask);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      in_mode_r  <= '0;
      irq_mask_r <= '0;
      lbl_addr_r <= '0;
      for (int i = 0; i < 3; i++)
      begin
        on_en_r[i]  <= `LSIO_EVT_EN_RST;
        off_en_r[i] <= `LSIO_EVT_EN_RST;
      end
      for (int i = 0; i < 8; i++)
        route_r[i] <= `LSIO_ROUTE_RST;
    end
    else
    begin
      if (w_mode)
        in_mode_r <= lsio_merge(in_mode_r, avs_writedata, be_mask);
      if (w_imask)
        irq_mask_r <= wr_bits[`LSIO_IRQ_W-1:0] | (irq_mask_r & ~be_mask[`LSIO_IRQ_W-1:0]);
      if (w_laddr)
        lbl_addr_r <= laddr_m[9:0];
      if (w_on)
        on_en_r[on_sel] <= lsio_merge(on_en_r[on_sel], avs_writedata, be_mask);
      if (w_off)
        off_en_r[off_sel] <= lsio_merge(off_en_r[off_sel], avs_writedata, be_mask);
      if (w_route)
        route_r[rt_sel] <= lsio_merge(route_r[rt_sel], avs_writedata, be_mask);
    end
  end

  // ----------------------------------------
  // Result signals and routing
  // ----------------------------------------
  logic [63:0] out_q_r;
  wire  [63:0] rt_blk = {route_r[1], route_r[0]};
  wire  [63:0] rt_grp = {route_r[3], route_r[2]};
  wire  [63:0] rt_rly = {route_r[5], route_r[4]};
  wire  [63:0] rt_lmp = {route_r[7], route_r[6]};

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_q_r      <= '0;
      func_block   <= '0;
      group_change <= '0;
      relay_drive  <= '0;
      lamp_drive   <= '0;
    end
    else
    begin
      out_q_r      <= user_logic_result_signal;
      func_block   <= out_q_r & rt_blk;
      group_change <= out_q_r & rt_grp;
      relay_drive  <= out_q_r & rt_rly;
      lamp_drive   <= out_q_r & rt_lmp;
    end
  end

  // ----------------------------------------
  // Commanded inputs
  // ----------------------------------------
  for (genvar i = 0; i < `LSIO_N_IN; i++)
  begin : g_cell
    wire mim_hit = mimic_index == 5'(i);
    lsio_cmd_cell #(
      .CNT_W        (`LSIO_PULSE_CNT_W),
      .PULSE_CYCLES (PULSE_CYCLES)
    ) u_cell (
      .clk     (clk),
      .nrst    (nrst),
      .set_cmd ((w_set & wr_bits[i]) | (mimic_set & mim_hit)),
      .clr_cmd ((w_clr & wr_bits[i]) | (mimic_clr & mim_hit)),
      .mode    (lsio_pkg::lsio_mode_type'(in_mode_r[i])),
      .status  (commanded_binary_signal[i])
    );
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  logic [NS-1:0] prev_r;
  logic [NS-1:0] pend_on_r;
  logic [NS-1:0] pend_off_r;
  logic [31:0]   stamp_on_r  [0:NS-1];
  logic [31:0]   stamp_off_r [0:NS-1];

  wire [NS-1:0] sig_all = {out_q_r[63:32], commanded_binary_signal, out_q_r[31:0]};
  wire [NS-1:0] en_on   = {on_en_r[2], on_en_r[1], on_en_r[0]};
  wire [NS-1:0] en_off  = {off_en_r[2], off_en_r[1], off_en_r[0]};
  wire [NS-1:0] rise    = sig_all & ~prev_r & en_on;
  wire [NS-1:0] fall    = ~sig_all & prev_r & en_off;

  // Lowest pending signal goes out first
  logic [6:0]    pick_idx;
  logic          pick_found;
  always_comb
  begin
    pick_idx   = '0;
    pick_found = 1'b0;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (pend_on_r[i] | pend_off_r[i])
      begin
        pick_idx   = 7'(i);
        pick_found = 1'b1;
      end
    end
  end

  // Both pending: the older stamp leaves first
  wire          pick_on  = pend_on_r[pick_idx] &
                           (~pend_off_r[pick_idx] |
                            (stamp_on_r[pick_idx] <= stamp_off_r[pick_idx]));
  wire [NS-1:0] pick_vec = NS'(pick_found) << pick_idx;
  wire [NS-1:0] clr_on   = pick_on ? pick_vec : '0;
  wire [NS-1:0] clr_off  = pick_on ? '0 : pick_vec;
  wire          ovr_hit  = |((rise & pend_on_r & ~clr_on) | (fall & pend_off_r & ~clr_off));

  // New change wins over the slot being emitted
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prev_r     <= '0;
      pend_on_r  <= '0;
      pend_off_r <= '0;
    end
    else
    begin
      prev_r     <= sig_all;
      pend_on_r  <= (pend_on_r & ~clr_on) | rise;
      pend_off_r <= (pend_off_r & ~clr_off) | fall;
    end
  end

  // Stamps are data only, no reset needed
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NS; i++)
    begin
      if (rise[i])
        stamp_on_r[i] <= time_stamp;
      if (fall[i])
        stamp_off_r[i] <= time_stamp;
    end
  end

  // Event port, one event per clock
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      evt_valid <= 1'b0;
      evt_group <= lsio_pkg::grp_none;
      evt_index <= '0;
      evt_on    <= 1'b0;
      evt_stamp <= '0;
    end
    else
    begin
      evt_valid <= pick_found;
      evt_index <= pick_idx[4:0];
      evt_on    <= pick_on;
      evt_stamp <= pick_on ? stamp_on_r[pick_idx] : stamp_off_r[pick_idx];
      case (pick_idx[6:5])
        2'h0:    evt_group <= lsio_pkg::event_group_outputs_low;
        2'h1:    evt_group <= lsio_pkg::event_group_inputs;
        2'h2:    evt_group <= lsio_pkg::event_group_outputs_high;
        default: evt_group <= lsio_pkg::grp_none;
      endcase
      if (!pick_found)
        evt_group <= lsio_pkg::grp_none;
    end
  end

  // ----------------------------------------
  // Labels: edit bank and history bank
  // ----------------------------------------
  lsio_pkg::lsio_cpy_type cpy_state_r;
  logic [9:0]    cpy_cnt_r;
  logic          cpy_wr_r;
  logic [9:0]    cpy_waddr_r;
  logic [NS-1:0] edit_custom_r;
  logic [NS-1:0] hist_custom_r;
  logic [9:0]    hist_addr_d_r;
  logic [31:0]   edit_rdata;
  logic [31:0]   hist_rdata;

  wire        lbl_ok    = lbl_addr_r[9:3] < 7'(NS);
  wire        lbl_we    = w_ldata & lbl_ok;
  // Top byte of the last word is the terminator, capping text at 31
  wire [31:0] lbl_wdata = (lbl_addr_r[2:0] == 3'h7) ? wr_bits & `LSIO_LAST_BYTE : wr_bits;
  wire        cpy_busy  = cpy_state_r == lsio_pkg::cpy_run;
  wire [9:0]  edit_ra   = cpy_busy ? cpy_cnt_r : lbl_addr_r;
  wire        cpy_done  = cpy_wr_r && cpy_waddr_r == 10'(LW - 1);
  wire [31:0] lbl_rd    = (lbl_ok && edit_custom_r[lbl_addr_r[9:3]]) ? edit_rdata :
                          lsio_default_word(lbl_addr_r[9:3], lbl_addr_r[2:0]);

  lsio_label_ram #(.DW(32), .AW(`LSIO_LBL_AW), .DEPTH(LW)) u_edit_ram (
    .clk   (clk),
    .nrst  (nrst),
    .we    (lbl_we),
    .waddr (lbl_addr_r),
    .wdata (lbl_wdata),
    .raddr (edit_ra),
    .rdata (edit_rdata)
  );

  lsio_label_ram #(.DW(32), .AW(`LSIO_LBL_AW), .DEPTH(LW)) u_hist_ram (
    .clk   (clk),
    .nrst  (nrst),
    .we    (cpy_wr_r),
    .waddr (cpy_waddr_r),
    .wdata (edit_rdata),
    .raddr (hist_label_addr),
    .rdata (hist_rdata)
  );

  // Copy edited labels into the history bank on operator restart
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cpy_state_r   <= lsio_pkg::cpy_idle;
      cpy_cnt_r     <= '0;
      cpy_wr_r      <= 1'b0;
      cpy_waddr_r   <= '0;
      edit_custom_r <= '0;
      hist_custom_r <= '0;
    end
    else
    begin
      cpy_wr_r    <= cpy_busy;
      cpy_waddr_r <= cpy_cnt_r;
      if (lbl_we)
        edit_custom_r[lbl_addr_r[9:3]] <= 1'b1;
      case (cpy_state_r)
        lsio_pkg::cpy_idle:
        begin
          if (w_hmi && wr_bits[0])
          begin
            cpy_state_r   <= lsio_pkg::cpy_run;
            cpy_cnt_r     <= '0;
            hist_custom_r <= edit_custom_r;
          end
        end
        lsio_pkg::cpy_run:
        begin
          cpy_cnt_r <= cpy_cnt_r + 10'h001;
          if (cpy_cnt_r == 10'(LW - 1))
            cpy_state_r <= lsio_pkg::cpy_idle;
        end
        default: cpy_state_r <= lsio_pkg::cpy_idle;
      endcase
    end
  end

  // History lookup, default text until a custom label is published
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      hist_addr_d_r   <= '0;
      hist_label_data <= '0;
    end
    else
    begin
      hist_addr_d_r   <= hist_label_addr;
      hist_label_data <= (hist_addr_d_r[9:3] < 7'(NS) && hist_custom_r[hist_addr_d_r[9:3]]) ?
                         hist_rdata : lsio_default_word(hist_addr_d_r[9:3], hist_addr_d_r[2:0]);
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [`LSIO_IRQ_W-1:0] irq_stat_r;
  wire  [`LSIO_IRQ_W-1:0] irq_set = {cpy_done, ovr_hit, pick_found};
  wire  [`LSIO_IRQ_W-1:0] irq_w1c = w_istat ? wr_bits[`LSIO_IRQ_W-1:0] : '0;

  // Set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      irq_stat_r <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_set;
      irq        <= |(((irq_stat_r & ~irq_w1c) | irq_set) & irq_mask_r);
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    case (avs_address)
      `LSIO_OFS_OUT_LO:   rd_mux = out_q_r[31:0];
      `LSIO_OFS_OUT_HI:   rd_mux = out_q_r[63:32];
      `LSIO_OFS_IN_STAT:  rd_mux = commanded_binary_signal;
      `LSIO_OFS_IN_MODE:  rd_mux = in_mode_r;
      `LSIO_OFS_IRQ_STAT: rd_mux = 32'(irq_stat_r);
      `LSIO_OFS_IRQ_MASK: rd_mux = 32'(irq_mask_r);
      `LSIO_OFS_LBL_ADDR: rd_mux = 32'(lbl_addr_r);
      `LSIO_OFS_LBL_DATA: rd_mux = lbl_rd;
      `LSIO_OFS_HMI_RST:  rd_mux = 32'(cpy_busy);
      default:
      begin
        if (widx >= 6'h06 && widx <= 6'h08)
          rd_mux = on_en_r[on_sel];
        else if (widx >= 6'h09 && widx <= 6'h0B)
          rd_mux = off_en_r[off_sel];
        else if (widx >= 6'h11 && widx <= 6'h18)
          rd_mux = route_r[rt_sel];
      end
    endcase
  end

  // Data captured as waitrequest drops, held until the next read
  always_ff @(posedge clk)
  begin
    if (!nrst)
      avs_readdata <= '0;
    else if (avs_read && wait_r)
      avs_readdata <= rd_mux;
  end

  assign avs_waitrequest = wait_r;

endmodule : lsio_logic_signals

// File: testbench/lsio_mimic_model.sv
`timescale 1ns/1ns

module lsio_mimic_model (
  // Clock and operator action
  input  wire logic       clk,
  input  wire logic       press,
  input  wire logic       to_one,
  input  wire logic [4:0] sel,
  // Switch command pins
  output logic            mimic_set   = 1'b0,
  output logic            mimic_clr   = 1'b0,
  output logic      [4:0] mimic_index = 5'h00
);
  // One-cycle command per press; idle index inverted so stale values never pass
  always @(posedge clk)
  begin
    mimic_set   <= press & to_one;
    mimic_clr   <= press & ~to_one;
    mimic_index <= press ? sel : ~mimic_index;
  end
endmodule : lsio_mimic_model

// File: testbench/lsio_chk_sva.sv
`timescale 1ns/1ns

module lsio_chk (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   nrst,
  // Bus handshake
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic                   avs_waitrequest,
  // Commands and results
  input wire logic                   mimic_set,
  input wire logic                   mimic_clr,
  input wire logic [4:0]             mimic_index,
  input wire logic [63:0]            user_logic_result_signal,
  input wire logic [31:0]            commanded_binary_signal,
  input wire logic [63:0]            func_block,
  // Events
  input wire logic                   evt_valid,
  input wire lsio_pkg::lsio_grp_type evt_group
);
  // Single domain, so one clock and reset serve all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_WAIT: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  AST_WLOW: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low longer than one cycle");
  AST_GRP: assert property (evt_valid |-> evt_group != lsio_pkg::grp_none)
    else $error("event without block");
  AST_NOEVT: assert property (!evt_valid |-> evt_group == lsio_pkg::grp_none)
    else $error("block shown without event");
  AST_EVT: assert property (commanded_binary_signal != $past(commanded_binary_signal) |-> ##[1:8] evt_valid)
    else $error("input change gave no event");
  AST_SET: assert property (mimic_set |-> ##2 commanded_binary_signal[$past(mimic_index, 2)])
    else $error("switch set not applied");
  AST_CLR: assert property (mimic_clr && !mimic_set |-> ##2 !commanded_binary_signal[$past(mimic_index, 2)])
    else $error("switch clear not applied");
  AST_ROUTE: assert property ((func_block & ~$past(user_logic_result_signal, 2)) == 64'h0)
    else $error("blocking without result");
endmodule : lsio_chk

bind lsio_logic_signals lsio_chk chk_u (.clk(clk), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mimic_set(mimic_set),
  .mimic_clr(mimic_clr), .mimic_index(mimic_index), .func_block(func_block),
  .user_logic_result_signal(user_logic_result_signal), .evt_valid(evt_valid),
  .commanded_binary_signal(commanded_binary_signal), .evt_group(evt_group));

// File: testbench/tb.sv
`timescale 1ns/1ns
`define CHK(a, e) n_tests++; if ((a) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, a, e); end

module tb;
  logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        press = 1'b0, one = 1'b0, ms, mc, wq, ev_v, ev_on, irq;
  logic [4:0]  sel = 5'h00, mi, ev_i;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, stamp = 32'h0, q, rq, cbs, es, hd;
  logic [63:0] ulr = 64'h0, fb, gc, rl, lm;
  lsio_pkg::lsio_grp_type ev_g;
  int          fails = 0, n_tests = 0, cyc = 0, n;

  // Clock, time base and hang guard
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    stamp <= stamp + 32'h1;
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out;
    end
  end

  lsio_mimic_model sw_u (.clk(clk), .press(press), .to_one(one), .sel(sel),
    .mimic_set(ms), .mimic_clr(mc), .mimic_index(mi));
  lsio_logic_signals #(.PULSE_CYCLES(20)) dut_u (.clk(clk), .nrst(nrst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(4'hF), .avs_writedata(wd),
    .avs_readdata(rq), .avs_waitrequest(wq), .user_logic_result_signal(ulr),
    .time_stamp(stamp), .mimic_set(ms), .mimic_clr(mc), .mimic_index(mi),
    .commanded_binary_signal(cbs), .func_block(fb), .group_change(gc), .relay_drive(rl),
    .lamp_drive(lm), .evt_valid(ev_v), .evt_group(ev_g), .evt_index(ev_i), .evt_on(ev_on),
    .evt_stamp(es), .hist_label_addr(10'h000), .hist_label_data(hd), .irq(irq));

  // Held until the edge that samples wait low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    do @(posedge clk); while (wq !== 1'b0);
    q = rq;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic ev(input logic [1:0] g, input logic [4:0] i, input logic o);
    do @(negedge clk); while (ev_v !== 1'b1);
    `CHK(ev_g, g)
    `CHK({ev_i, ev_on}, {i, o})
  endtask : ev

  task automatic mimic(input logic o, input logic [4:0] i);
    @(posedge clk);
    press <= 1'b1;
    one   <= o;
    sel   <= i;
    @(posedge clk);
    press <= 1'b0;
    ev(2'b10, i, o);
  endtask : mimic

  task automatic t_regs;
    bus(1'b0, 8'h18, 32'h0);
    `CHK(q, 32'hFFFF_FFFF)
    bus(1'b0, 8'hF0, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 8'h38, 32'h0);
    bus(1'b0, 8'h3C, 32'h0);
    `CHK(q, 32'h6967_6F4C)
    $display("regs done");
  endtask : t_regs

  task automatic t_inputs;
    bus(1'b1, 8'h34, 32'h1);
    bus(1'b1, 8'h10, 32'h8);
    ev(2'b10, 5'd3, 1'b1);
    repeat (40) @(negedge clk);
    `CHK(cbs, 32'h8)
    `CHK(irq, 1'b1)
    bus(1'b1, 8'h14, 32'h8);
    ev(2'b10, 5'd3, 1'b0);
    mimic(1'b1, 5'd9);
    `CHK(cbs, 32'h200)
    mimic(1'b0, 5'd9);
    bus(1'b1, 8'h30, 32'h7);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    $display("inputs done");
  endtask : t_inputs

  task automatic t_outputs;
    for (int k = 0; k < 4; k++)
      bus(1'b1, 8'(8'h48 + 8'h08 * k), 32'h100);
    n = stamp;
    ulr <= 64'h0000_0100_0000_0001;
    ev(2'b01, 5'd0, 1'b1);
    ev(2'b11, 5'd8, 1'b1);
    `CHK(es, 32'(n + 2))
    `CHK(fb, 64'h0000_0100_0000_0000)
    `CHK({gc, rl, lm}, {3{64'h0000_0100_0000_0000}})
    bus(1'b0, 8'h04, 32'h0);
    `CHK(q, 32'h100)
    $display("outputs done");
  endtask : t_outputs

  task automatic t_pulse;
    bus(1'b1, 8'h0C, 32'h20);
    bus(1'b1, 8'h10, 32'h20);
    do @(negedge clk); while (cbs[5] !== 1'b1);
    n = 0;
    while (cbs[5] === 1'b1 && n < 99)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n, 20)
    bus(1'b1, 8'h10, 32'h20);
    repeat (5) @(negedge clk);
    bus(1'b1, 8'h10, 32'h20);
    @(negedge clk);
    n = 0;
    while (cbs[5] === 1'b1 && n < 99)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n, 20)
    $display("pulse done");
  endtask : t_pulse

  // History keeps the old text until the copy has run
  task automatic t_label;
    bus(1'b1, 8'h3C, 32'h4142_4344);
    bus(1'b0, 8'h3C, 32'h0);
    `CHK(q, 32'h4142_4344)
    `CHK(hd, 32'h6967_6F4C)
    bus(1'b1, 8'h40, 32'h1);
    repeat (800) @(negedge clk);
    `CHK(hd, 32'h4142_4344)
    $display("labels done");
  endtask : t_label

  task automatic t_reboot;
    bus(1'b1, 8'h10, 32'h2);
    ev(2'b10, 5'd1, 1'b1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK(cbs, 32'h0)
    $display("reboot done");
  endtask : t_reboot

  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_inputs;
    t_outputs;
    t_pulse;
    t_label;
    t_reboot;
    close_out;
  end
endmodule : tb
